//--- rtl/stp_pkg.sv
`default_nettype none

package stp_pkg;

    // ------------------------------------------------------------
    // Word and divider shape
    // ------------------------------------------------------------
    localparam int unsigned WORD_BITS   = 4;
    localparam int unsigned DIV4_RATIO  = 4;
    localparam int unsigned DIV8_RATIO  = 8;
    localparam int unsigned PHASE_BITS  = 3;

    // Bit-slip pulse must stay high this many sampled cycles
    localparam int unsigned SLIP_MIN_CYCLES = 2;

    // Reset values
    localparam logic [PHASE_BITS-1:0] PHASE_RESET = 3'h0;
    localparam logic [WORD_BITS-1:0]  WORD_RESET  = 4'h0;

    // Phase at which a word is complete, and the divider step
    localparam logic [PHASE_BITS-1:0] PHASE_LAST4 = 3'h3;
    localparam logic [PHASE_BITS-1:0] PHASE_LAST8 = 3'h7;
    localparam logic [PHASE_BITS-1:0] PHASE_ONE   = 3'h1;

    // Slip detector states
    typedef enum logic [1:0] {
        STP_SLIP_IDLE,
        STP_SLIP_HIGH,
        STP_SLIP_ARMED
    } stp_slip_type;

endpackage

`default_nettype wire

//--- rtl/stp_sync2.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Two-flop synchroniser for pin inputs
// ------------------------------------------------------------
module stp_sync2 #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             sys_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            meta_q   <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

`default_nettype wire

//--- rtl/stp_converter.sv
`timescale 1ns/1ps
`default_nettype none

module stp_converter (
    input  wire logic                           sys_clk,
    input  wire logic                           reset,
    input  wire logic                           serial_in_a,
    input  wire logic                           serial_in_b,
    input  wire logic                           input_select,
    input  wire logic                           mode_8bit,
    input  wire logic                           bit_slip_in,
    output var  logic [stp_pkg::WORD_BITS-1:0]  parallel_out,
    output var  logic                           div4_clock_out,
    output var  logic                           div4_clock_out_n,
    output var  logic                           div8_clock_out,
    output var  logic                           div8_clock_out_n
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] pins_raw;
    logic [4:0] pins_sync;
    wire        sin_a_s;
    wire        sin_b_s;
    wire        sel_s;
    wire        mode_s;
    wire        slip_s;

    assign pins_raw = {serial_in_a, serial_in_b, input_select, mode_8bit, bit_slip_in};

    stp_sync2 #(
        .WIDTH    (5)
    ) u_sync (
        .sys_clk  (sys_clk),
        .reset    (reset),
        .async_in (pins_raw),
        .sync_out (pins_sync)
    );

    // All pins share one latency, so data and select stay aligned
    assign sin_a_s = pins_sync[4];
    assign sin_b_s = pins_sync[3];
    assign sel_s   = pins_sync[2];
    assign mode_s  = pins_sync[1];
    assign slip_s  = pins_sync[0];

    // ------------------------------------------------------------
    // Input selection
    // ------------------------------------------------------------
    wire serial_bit;
    assign serial_bit = sel_s ? sin_a_s : sin_b_s;

    // ------------------------------------------------------------
    // Bit-slip detection
    // ------------------------------------------------------------
    // Each qualified pulse yields one swallow; a held level
    // does not repeat, so each shift needs a new pulse.
    stp_pkg::stp_slip_type slip_state_q;
    stp_pkg::stp_slip_type slip_state_d;
    logic                  swallow;

    always_comb
    begin
        slip_state_d = slip_state_q;
        swallow      = 1'b0;
        case (slip_state_q)
            stp_pkg::STP_SLIP_IDLE:
            begin
                if (slip_s)
                begin
                    slip_state_d = stp_pkg::STP_SLIP_HIGH;
                end
            end
            stp_pkg::STP_SLIP_HIGH:
            begin
                // Second high sample meets the two-cycle minimum
                if (!slip_s)
                begin
                    slip_state_d = stp_pkg::STP_SLIP_IDLE;
                end
                else
                begin
                    swallow      = 1'b1;
                    slip_state_d = stp_pkg::STP_SLIP_ARMED;
                end
            end
            stp_pkg::STP_SLIP_ARMED:
            begin
                if (!slip_s)
                begin
                    slip_state_d = stp_pkg::STP_SLIP_IDLE;
                end
            end
            default:
            begin
                slip_state_d = stp_pkg::STP_SLIP_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            slip_state_q <= stp_pkg::STP_SLIP_IDLE;
        end
        else
        begin
            slip_state_q <= slip_state_d;
        end
    end

    // ------------------------------------------------------------
    // Divider phase
    // ------------------------------------------------------------
    // A swallow holds the phase for one clock, so the word
    // boundary moves one bit later in the stream.
    logic [stp_pkg::PHASE_BITS-1:0] phase_q;
    logic [stp_pkg::PHASE_BITS-1:0] phase_d;

    // Divider step; the count wraps at the top of its range
    function automatic logic [stp_pkg::PHASE_BITS-1:0] phase_step(
        input logic [stp_pkg::PHASE_BITS-1:0] phase
    );
        phase_step = phase + stp_pkg::PHASE_ONE;
    endfunction

    assign phase_d = swallow ? phase_q : phase_step(phase_q);

    // Reset puts every device in the same phase
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            phase_q <= stp_pkg::PHASE_RESET;
        end
        else
        begin
            phase_q <= phase_d;
        end
    end

    // ------------------------------------------------------------
    // Shift register and word load
    // ------------------------------------------------------------
    logic [stp_pkg::WORD_BITS-1:0] shift_q;
    logic [stp_pkg::WORD_BITS-1:0] shift_d;
    wire                           word_done;
    wire                           load_word;

    // New bit enters the top; the oldest ends at bit 0
    assign shift_d = {serial_bit, shift_q[stp_pkg::WORD_BITS-1:1]};

    // Swallowed cycle is not a word boundary
    assign word_done = !swallow &&
                       (phase_q[1:0] == stp_pkg::PHASE_LAST4[1:0]);
    assign load_word = mode_s ? (word_done && phase_q == stp_pkg::PHASE_LAST8)
                              : word_done;

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            shift_q      <= stp_pkg::WORD_RESET;
            parallel_out <= stp_pkg::WORD_RESET;
        end
        else
        begin
            shift_q <= shift_d;
            if (load_word)
            begin
                parallel_out <= shift_d;
            end
        end
    end

    // ------------------------------------------------------------
    // Divided clock outputs
    // ------------------------------------------------------------
    // Rising edge of div4 coincides with each 4-bit word load
    wire div4_next;
    wire div8_next;
    assign div4_next = ~phase_d[1];
    assign div8_next = ~phase_d[2];

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            div4_clock_out   <= 1'b0;
            div4_clock_out_n <= 1'b1;
            div8_clock_out   <= 1'b0;
            div8_clock_out_n <= 1'b1;
        end
        else
        begin
            div4_clock_out   <= div4_next;
            div4_clock_out_n <= ~div4_next;
            div8_clock_out   <= div8_next;
            div8_clock_out_n <= ~div8_next;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_word_first_bit: assert property (@(posedge sys_clk) disable iff (reset)
        $past(load_word) |-> parallel_out[0] == $past(shift_q[1]))
        else $error("parallel bit 0 not oldest bit");

    a_div4_pair: assert property (@(posedge sys_clk) disable iff (reset)
        div4_clock_out != div4_clock_out_n)
        else $error("div4 pair not complementary");

    a_div8_pair: assert property (@(posedge sys_clk) disable iff (reset)
        div8_clock_out != div8_clock_out_n)
        else $error("div8 pair not complementary");

    a_slip_two_high: assert property (@(posedge sys_clk) disable iff (reset)
        swallow |-> slip_s && $past(slip_s) && !$past(swallow))
        else $error("swallow without two-cycle slip");

    a_slip_holds_phase: assert property (@(posedge sys_clk) disable iff (reset)
        swallow |=> phase_q == $past(phase_q))
        else $error("swallow did not hold phase");

    a_phase_advances: assert property (@(posedge sys_clk) disable iff (reset)
        !swallow |=> phase_q == phase_step($past(phase_q)))
        else $error("phase did not advance");

    a_mode4_spacing: assert property (@(posedge sys_clk) disable iff (reset)
        load_word && !mode_s |=> !load_word [*3])
        else $error("4-bit loads closer than four");

    a_mode8_spacing: assert property (@(posedge sys_clk) disable iff (reset)
        load_word && mode_s |=> !(load_word && mode_s) [*7])
        else $error("8-bit loads closer than eight");

    a_load_div4_rise: assert property (@(posedge sys_clk) disable iff (reset)
        load_word && !mode_s |=> div4_clock_out && !$past(div4_clock_out))
        else $error("word load not on div4 rise");

    a_select_path: assert property (@(posedge sys_clk) disable iff (reset)
        shift_q[stp_pkg::WORD_BITS-1] == $past(sel_s ? sin_a_s : sin_b_s))
        else $error("wrong serial input taken");

    a_loaded_newest: assert property (@(posedge sys_clk) disable iff (reset)
        load_word |=> parallel_out[stp_pkg::WORD_BITS-1] == $past(serial_bit))
        else $error("newest bit not on top output");

    a_word_stable: assert property (@(posedge sys_clk) disable iff (reset)
        !load_word |=> $stable(parallel_out))
        else $error("parallel word changed between loads");

    a_mode8_div8_rise: assert property (@(posedge sys_clk) disable iff (reset)
        load_word && mode_s |=> $rose(div8_clock_out))
        else $error("8-bit load not on div8 rise");

    // ------------------------------------------------------------
    // Divider and slip checks
    // ------------------------------------------------------------
    // Mode changes move no divider edge, so these hold in both modes
    a_div8_on_div4: assert property (@(posedge sys_clk) disable iff (reset)
        $changed(div8_clock_out) |-> $rose(div4_clock_out))
        else $error("div8 edge not on div4 rise");

    a_div4_fall_hold: assert property (@(posedge sys_clk) disable iff (reset)
        $fell(div4_clock_out) |=> !div4_clock_out)
        else $error("div4 low half too short");

    a_short_slip_ignored: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(slip_s) ##1 !slip_s |-> !swallow)
        else $error("one-cycle slip caused a swallow");

    a_held_slip_once: assert property (@(posedge sys_clk) disable iff (reset)
        swallow |=> !swallow [*2])
        else $error("slip swallowed more than once");

    a_swallow_no_load: assert property (@(posedge sys_clk) disable iff (reset)
        swallow |-> !load_word)
        else $error("word loaded on a swallowed cycle");

    // Reset must leave every device in one known phase
    a_reset_clears: assert property (@(posedge sys_clk)
        reset |=> phase_q == stp_pkg::PHASE_RESET && parallel_out == stp_pkg::WORD_RESET
                  && !div4_clock_out && !div8_clock_out)
        else $error("reset left state uncleared");

endmodule

`default_nettype wire

//--- dv/stp_serial_source.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Random serial source on both data pins
// ------------------------------------------------------------
module stp_serial_source (
    input  wire logic sys_clk,
    output var  logic serial_a,
    output var  logic serial_b
);
    // Fresh bits just after each edge; both pins always driven
    initial
    begin
        serial_a = 1'b0;
        serial_b = 1'b0;
        forever
        begin
            @(posedge sys_clk);
            #1;
            serial_a = 1'($urandom);
            serial_b = 1'($urandom);
        end
    end
endmodule
`default_nettype wire

//--- dv/test_serial_to_parallel_4bit.sv
`timescale 1ns/1ps
`default_nettype none

module test_serial_to_parallel_4bit;
    logic       sys_clk, reset, sel, mode8, slip, sin_a, sin_b;
    logic       d4, d4_n, d8, d8_n, p4, p8, fresh;
    logic [3:0] pout, pp, acc;
    logic [3:0] exp_q[$];
    int         due_q[$];
    int         failures, cmp_count, ecount, off, quiet, l4, l8, r4, r8, slips, exp_slips;

    // ------------------------------------------------------------
    // Clock, source and design
    // ------------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    stp_serial_source src (.sys_clk(sys_clk), .serial_a(sin_a), .serial_b(sin_b));

    stp_converter DUT (.sys_clk(sys_clk), .reset(reset), .serial_in_a(sin_a),
        .serial_in_b(sin_b), .input_select(sel), .mode_8bit(mode8),
        .bit_slip_in(slip), .parallel_out(pout), .div4_clock_out(d4),
        .div4_clock_out_n(d4_n), .div8_clock_out(d8), .div8_clock_out_n(d8_n));

    task automatic check4(input logic [3:0] got, input logic [3:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons=%0d mismatches=%0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Drive changes land just after an edge, never on it
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge sys_clk);
            #1;
        end
    endtask

    // Group the selected pin's bits into the words due out
    always @(posedge sys_clk)
    begin : rec
        int n, k;
        ecount = reset ? -1 : ecount + 1;
        n = mode8 ? 8 : 4;
        // Pin bits reach a load two edges after they are sampled
        k = ((ecount - off + 2) % n + n) % n - (n - 4);
        if (reset || quiet != 0)
            fresh = 1'b0;
        else if (k >= 0)
        begin
            acc[k] = sel ? sin_a : sin_b;
            fresh = fresh | (k == 0);
            if (k == 3 && fresh)
            begin
                exp_q.push_back(acc);
                due_q.push_back(ecount + 2);
            end
        end
    end

    // Oldest note is taken at the first divider rise once due
    always @(negedge sys_clk)
    begin
        if (reset !== 1'b0)
        begin
            r4 = 0;
            r8 = 0;
        end
        else
        begin
            check4({2'h0, d4_n, d8_n}, {2'h0, ~d4, ~d8});
            // First divider period after reset is short, so spacing starts later
            if (d4 && !p4)
            begin
                if (r4 >= 2 && ecount - l4 == 5)
                    slips++;
                else if (r4 >= 2)
                    check4(4'(ecount - l4), 4'h4);
                l4 = ecount;
                r4++;
            end
            if (d8 && !p8)
            begin
                if (r8 >= 2 && ecount - l8 != 9)
                    check4(4'(ecount - l8), 4'h8);
                l8 = ecount;
                r8++;
            end
            if (quiet == 0 && d4 && !p4 && due_q.size() > 0 && ecount >= due_q[0])
            begin
                void'(due_q.pop_front());
                check4(pout, exp_q.pop_front());
            end
            else if (quiet == 0 && (!(d4 && !p4) || (mode8 && d8_n)))
                check4(pout, pp);
        end
        p4 = d4;
        p8 = d8;
        pp = pout;
    end

    // Master reset realigns every divider and the word boundary
    task automatic do_reset();
        quiet = 1;
        reset = 1'b1;
        tick(15);
        off = 0;
        @(negedge sys_clk);
        check4({d4, d4_n, d8, d8_n}, 4'h5);
        check4(pout, 4'h0);
        tick(1);
        reset = 1'b0;
    endtask

    // Configure, optionally slip, flush the pipeline, then check words
    task automatic run_cfg(input logic s, input logic m, input int slip_len);
        static int t = 0;
        quiet = 1;
        sel = s;
        mode8 = m;
        // Random lead-in puts the slip at any divider phase
        tick(1 + $urandom % 8);
        repeat (slip_len)
        begin
            slip = 1'b1;
            tick(1);
        end
        slip = 1'b0;
        if (slip_len >= 2)
        begin
            off++;
            exp_slips++;
        end
        tick(12);
        exp_q.delete();
        due_q.delete();
        quiet = 0;
        tick(64);
        quiet = 1;
        check4(4'(slips), 4'(exp_slips));
        t++;
        $display("test %0d done", t);
    endtask

    // Main sequence; a one-cycle slip must be ignored, a held one counts once
    initial
    begin
        sel = 1'b1;
        mode8 = 1'b0;
        slip = 1'b0;
        void'($urandom(32'hFA4E));
        do_reset();
        run_cfg(1'b1, 1'b0, 0);
        run_cfg(1'b0, 1'b0, 0);
        run_cfg(1'b1, 1'b1, 0);
        run_cfg(1'b0, 1'b1, 2);
        run_cfg(1'b1, 1'b0, 2);
        run_cfg(1'b0, 1'b0, 1);
        run_cfg(1'b1, 1'b0, 6);
        run_cfg(1'b1, 1'b1, 3);
        do_reset();
        run_cfg(1'b0, 1'b0, 0);
        give_verdict();
    end

    // Watchdog well beyond the expected run length
    initial
    begin
        #300000;
        failures++;
        give_verdict();
    end
endmodule
`default_nettype wire
